/* logic/pid_pkg.sv */
package pid_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_PAR0 = 8'h08;
  localparam logic [7:0] REG_PAR6 = 8'h20;
  localparam logic [7:0] REG_INP = 8'h24;
  localparam logic [7:0] REG_OUT = 8'h28;
  // status bit positions
  localparam int STAT_ERR = 0;
  localparam int STAT_EXE = 1;
  localparam int STAT_RUN = 2;
  // reset values
  localparam logic [15:0] PAR_RST = 16'h0000;
  localparam logic [15:0] OUT_RST = 16'h0000;
  // axi responses
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // parameter encodings
  localparam logic [13:0] TIK_NONE = 14'd9999;
  localparam logic [13:0] TIK_MAX = 14'd8191;
  localparam logic [13:0] TAU_MAX_100 = 14'd1023;
  localparam logic [6:0] ALPHA_DEF = 7'd65;
  localparam logic [3:0] RANGE_MAX = 4'h8;
  localparam logic [3:0] TU_C100 = 4'h0;
  localparam logic [3:0] TU_C10 = 4'h1;
  localparam logic [3:0] TU_R100 = 4'h8;
  localparam logic [3:0] TU_R10 = 4'h9;
  localparam logic [31:0] PB_SCALE = 32'd1000;
  localparam logic [31:0] PCT_SCALE = 32'd100;
  // timing: 4 ns clock, 10 ms and 100 ms time units
  localparam int CLK_NS = 4;
  localparam int UNIT10_NS = 10_000_000;
  localparam int UNIT100_NS = 100_000_000;
  localparam int UNIT10_CYC_DEF = UNIT10_NS / CLK_NS;
  localparam int UNIT100_CYC_DEF = UNIT100_NS / CLK_NS;
  localparam int DIV_STEPS = 48;
  // latched loop settings
  typedef struct packed {
    logic [15:0] sv;
    logic [13:0] pb;
    logic [13:0] tik;
    logic [13:0] tdk;
    logic [13:0] tau;
    logic dir;
    logic [6:0] alpha;
    logic [3:0] in_rng;
    logic [3:0] tunit;
    logic [3:0] out_rng;
  } pid_par_t;
  // update sequencer, gray along the path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FILT = 3'b001,
    ST_PROP = 3'b011,
    ST_INTG = 3'b010,
    ST_DERV = 3'b110,
    ST_OUT = 3'b100
  } pid_state_t;
endpackage

/* logic/pid_loop_engine.sv */
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module pid_loop_engine import pid_pkg::*; #(
  parameter int UNIT10_CYC = UNIT10_CYC_DEF,
  parameter int UNIT100_CYC = UNIT100_CYC_DEF
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // loop status
  output logic [15:0] manipulated_output,
  output logic error_flag,
  output logic executing_flag
);

  // register file
  logic exec_q; // execution condition
  logic exec_prev_q; // for edge detection
  logic [15:0] par_q [7]; // parameter words
  logic [15:0] meas_q; // measured_value word
  logic [15:0] out_q; // manipulated_output word
  pid_par_t lat_q; // latched settings
  logic run_q; // loop running with valid settings
  logic first_q; // first update after start

  // bus handshake state
  logic aw_hold_q, w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // timing state
  logic [31:0] pre_q; // prescaler within one time unit
  logic [15:0] elap_q; // elapsed time units
  logic unit_tick;
  logic due;

  // arithmetic state
  pid_state_t st_q;
  logic signed [31:0] svf_q; // filtered target, normalised
  logic signed [31:0] pterm_q, pprev_q, iacc_q, dterm_q;
  logic signed [31:0] diff_c, sum_c;
  logic [47:0] div_num;
  logic [31:0] div_den;
  logic div_neg;
  logic div_go;
  logic div_busy_q, div_done_q;
  logic [47:0] quo_q;
  logic [31:0] rem_q;
  logic [5:0] dcnt_q;
  logic [32:0] rem_sh;
  logic signed [31:0] div_res;
  logic [15:0] pv_n, sv_n; // inputs shifted to 16-bit scale
  logic [3:0] in_sh, out_sh;

  // bcd word to binary, four digits
  function automatic logic [13:0] bcd4(input logic [15:0] b);
    logic [13:0] r;
    r = 14'(b[15:12]) * 14'd1000 + 14'(b[11:8]) * 14'd100
      + 14'(b[7:4]) * 14'd10 + 14'(b[3:0]);
    return r;
  endfunction

  // true when every nibble is a decimal digit
  function automatic logic is_bcd(input logic [15:0] b);
    return b[15:12] < 4'hA && b[11:8] < 4'hA && b[7:4] < 4'hA
      && b[3:0] < 4'hA;
  endfunction

  // clamp a wide signed value into a signed 32-bit band
  function automatic logic signed [31:0] clamp(
    input logic signed [47:0] v, input logic signed [31:0] lim);
    if (v > 48'(lim)) return lim;
    if (v < -48'(lim)) return -lim;
    return v[31:0];
  endfunction

  // decode raw words into settings and a validity check
  pid_par_t dec;
  logic par_ok;
  always_comb begin
    dec.sv = par_q[0];
    dec.pb = bcd4(par_q[1]);
    dec.tik = bcd4(par_q[2]);
    dec.tdk = bcd4(par_q[3]);
    dec.tau = bcd4(par_q[4]);
    dec.dir = par_q[5][0];
    // 000 is the normal 0.65, 1xx carries 0.xx
    dec.alpha = (par_q[5][15:4] == 12'h000) ? ALPHA_DEF
      : 7'(7'(par_q[5][11:8]) * 7'd10 + 7'(par_q[5][7:4]));
    dec.in_rng = par_q[6][11:8];
    dec.tunit = par_q[6][7:4];
    dec.out_rng = par_q[6][3:0];
    par_ok = is_bcd(par_q[1]) && is_bcd(par_q[2]) && is_bcd(par_q[3])
      && is_bcd(par_q[4]) && is_bcd(par_q[5]);
    par_ok = par_ok && dec.pb != 14'd0;
    // integral 1..8191 or the no-action code
    par_ok = par_ok && ((dec.tik != 14'd0 && dec.tik <= TIK_MAX)
      || dec.tik == TIK_NONE);
    par_ok = par_ok && dec.tdk <= TIK_MAX;
    // period 0001..9999, and at most 102.3 s in 100 ms units
    par_ok = par_ok && dec.tau != 14'd0;
    par_ok = par_ok && !((dec.tunit == TU_C100 || dec.tunit == TU_R100)
      && dec.tau > TAU_MAX_100);
    par_ok = par_ok && par_q[5][3:0] <= 4'h1;
    par_ok = par_ok && (par_q[5][15:4] == 12'h000
      || par_q[5][15:8] == 8'h10 || par_q[5][15:8] == 8'h11);
    par_ok = par_ok && dec.in_rng <= RANGE_MAX;
    par_ok = par_ok && dec.out_rng <= RANGE_MAX;
    par_ok = par_ok && par_q[6][15:12] == 4'h0;
    par_ok = par_ok && (dec.tunit == TU_C100 || dec.tunit == TU_C10
      || dec.tunit == TU_R100 || dec.tunit == TU_R10);
    // target may not exceed the input full scale
    par_ok = par_ok && (dec.in_rng > RANGE_MAX
      || (dec.sv >> (4'd8 + dec.in_rng)) == 16'h0000);
  end

  // axi write channel: address and data taken in either order
  logic wr_fire;
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
    end else if (ce) begin
      // ready is offered one cycle, then dropped after the take
      s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q[1:0] == 2'b00 && aw_addr_q <= REG_OUT)
          ? RESP_OK : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // merge a write into a 16-bit word under byte enables
  function automatic logic [15:0] merge(input logic [15:0] old);
    return {w_strb_q[1] ? w_data_q[15:8] : old[15:8],
            w_strb_q[0] ? w_data_q[7:0] : old[7:0]};
  endfunction

  // software-facing words; latched copy used only by the loop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exec_q <= 1'b0;
      meas_q <= PAR_RST;
      for (int i = 0; i < 7; i++) begin
        par_q[i] <= PAR_RST;
      end
    end else if (ce && wr_fire) begin
      if (aw_addr_q == REG_CTRL && w_strb_q[0]) begin
        exec_q <= w_data_q[0];
      end
      if (aw_addr_q == REG_INP) begin
        meas_q <= merge(meas_q);
      end
      for (int i = 0; i < 7; i++) begin
        if (aw_addr_q == REG_PAR0 + 8'(4 * i)) begin
          par_q[i] <= merge(par_q[i]);
        end
      end
    end
  end

  // axi read channel, answer one cycle after the take
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OK;
    end else if (ce) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OK;
        s_axi_rdata <= 32'h00000000;
        case (s_axi_araddr)
          REG_CTRL: s_axi_rdata[0] <= exec_q;
          REG_STAT: begin
            s_axi_rdata[STAT_ERR] <= error_flag;
            s_axi_rdata[STAT_EXE] <= executing_flag;
            s_axi_rdata[STAT_RUN] <= run_q;
          end
          REG_INP: s_axi_rdata[15:0] <= meas_q;
          REG_OUT: s_axi_rdata[15:0] <= out_q;
          default: begin
            if (s_axi_araddr >= REG_PAR0 && s_axi_araddr <= REG_PAR6
                && s_axi_araddr[1:0] == 2'b00) begin
              s_axi_rdata[15:0] <= par_q[3'((s_axi_araddr - REG_PAR0) >> 2)];
            end else begin
              s_axi_rresp <= RESP_SLVERR; // unmapped
            end
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // time-unit prescaler; only counts while running
  logic [31:0] unit_len;
  assign unit_len = (lat_q.tunit == TU_C10 || lat_q.tunit == TU_R10)
    ? 32'(UNIT10_CYC) : 32'(UNIT100_CYC);
  assign unit_tick = run_q && pre_q == unit_len - 32'd1;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 32'h00000000;
    end else if (ce) begin
      pre_q <= (!run_q || unit_tick) ? 32'h00000000 : pre_q + 32'd1;
    end
  end

  // an update is due once a full period has elapsed
  assign due = run_q && st_q == ST_IDLE && elap_q >= 16'(lat_q.tau);

  // start, latch and elapsed time
  logic start;
  assign start = exec_q && !exec_prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exec_prev_q <= 1'b0;
      run_q <= 1'b0;
      lat_q <= '0;
      elap_q <= 16'h0000;
    end else if (ce) begin
      exec_prev_q <= exec_q;
      if (start) begin
        // fresh settings only here
        lat_q <= dec;
        run_q <= par_ok;
        elap_q <= 16'(dec.tau); // first update right away
      end else if (!exec_q) begin
        run_q <= 1'b0; // settings and work values stay
      end else if (due) begin
        // carry the overshoot so the next gap is shorter
        elap_q <= elap_q - 16'(lat_q.tau) + 16'(unit_tick);
      end else if (unit_tick && elap_q != 16'hFFFF) begin
        elap_q <= elap_q + 16'h0001;
      end
    end
  end

  // error flag: bad settings or an interval of two periods
  // hardware set wins over a software clear in the same cycle
  logic err_set, err_clr;
  assign err_set = (start && !par_ok)
    || (due && !first_q && elap_q >= 16'(lat_q.tau) << 1);
  assign err_clr = wr_fire && aw_addr_q == REG_STAT
    && w_strb_q[0] && w_data_q[STAT_ERR];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      error_flag <= 1'b0;
    end else if (ce) begin
      if (err_set) begin
        error_flag <= 1'b1;
      end else if (err_clr) begin
        error_flag <= 1'b0;
      end
    end
  end

  // normalise measured and target to a 16-bit full scale
  assign in_sh = RANGE_MAX - lat_q.in_rng;
  assign out_sh = RANGE_MAX - lat_q.out_rng;
  assign pv_n = (meas_q & (16'hFFFF >> in_sh)) << in_sh;
  assign sv_n = lat_q.sv << in_sh;
  // deviation sign by direction of action
  assign diff_c = lat_q.dir ? 32'(pv_n) - svf_q : svf_q - 32'(pv_n);

  // divider operands per step
  logic rel;
  logic signed [31:0] fdev, dp;
  assign rel = lat_q.tunit == TU_R100 || lat_q.tunit == TU_R10;
  assign fdev = 32'(sv_n) - svf_q;
  assign dp = pterm_q - pprev_q;
  always_comb begin
    div_num = 48'h000000000000;
    div_den = 32'd1;
    div_neg = 1'b0;
    case (st_q)
      ST_FILT: begin
        // target filter: svf moves by (1 - alpha) of the gap
        div_num = 48'(fdev[31] ? -fdev : fdev) * 48'(7'd100 - lat_q.alpha);
        div_den = PCT_SCALE;
        div_neg = fdev[31];
      end
      ST_PROP: begin
        // gain is 100 % over the band in tenths of a percent
        div_num = 48'(diff_c[31] ? -diff_c : diff_c) * 48'(PB_SCALE);
        div_den = 32'(lat_q.pb);
        div_neg = diff_c[31];
      end
      ST_INTG: begin
        // per sample: p * tau / Ti for TU_R100/TU_R10, else p / Ti, so short Ti is strong
        div_num = (lat_q.tik == TIK_NONE) ? 48'h000000000000
          : 48'(pterm_q[31] ? -pterm_q : pterm_q) * 48'(rel ? lat_q.tau
          : 14'd1);
        div_den = 32'(lat_q.tik);
        div_neg = pterm_q[31];
      end
      ST_DERV: begin
        // dp * Td / tau for TU_R100/TU_R10, else dp * Td, so long Td is strong
        div_num = 48'(dp[31] ? -dp : dp) * 48'(lat_q.tdk);
        div_den = rel ? 32'(lat_q.tau) : 32'd1;
        div_neg = dp[31];
      end
      default: begin
        div_num = 48'h000000000000;
      end
    endcase
  end

  // shared restoring divider, one quotient bit per cycle
  assign div_go = st_q != ST_IDLE && st_q != ST_OUT
    && !div_busy_q && !div_done_q;
  assign rem_sh = {rem_q, quo_q[47]};
  assign div_res = clamp(div_neg ? -$signed(quo_q) : $signed(quo_q),
    32'sd131071);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_busy_q <= 1'b0;
      div_done_q <= 1'b0;
      quo_q <= 48'h000000000000;
      rem_q <= 32'h00000000;
      dcnt_q <= 6'h00;
    end else if (ce) begin
      div_done_q <= 1'b0;
      if (div_go) begin
        div_busy_q <= 1'b1;
        quo_q <= div_num;
        rem_q <= 32'h00000000;
        dcnt_q <= 6'(DIV_STEPS);
      end else if (div_busy_q) begin
        if (rem_sh >= {1'b0, div_den}) begin
          rem_q <= 32'(rem_sh - {1'b0, div_den});
          quo_q <= {quo_q[46:0], 1'b1};
        end else begin
          rem_q <= rem_sh[31:0];
          quo_q <= {quo_q[46:0], 1'b0};
        end
        dcnt_q <= dcnt_q - 6'h01;
        if (dcnt_q == 6'h01) begin
          div_busy_q <= 1'b0;
          div_done_q <= 1'b1;
        end
      end
    end
  end

  // update sequencer and work area
  assign sum_c = iacc_q + pterm_q + dterm_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
      first_q <= 1'b0;
      svf_q <= 32'sd0;
      pterm_q <= 32'sd0;
      pprev_q <= 32'sd0;
      iacc_q <= 32'sd0;
      dterm_q <= 32'sd0;
      out_q <= OUT_RST;
    end else if (ce) begin
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            // work area from the new settings
            first_q <= 1'b1;
            svf_q <= 32'(dec.sv << (RANGE_MAX - dec.in_rng));
            dterm_q <= 32'sd0;
          end else if (due) begin
            st_q <= ST_FILT;
          end else if (!exec_q && wr_fire && aw_addr_q == REG_OUT) begin
            out_q <= merge(out_q); // manual control
          end
        end
        ST_FILT: if (div_done_q) begin
          svf_q <= svf_q + div_res;
          st_q <= ST_PROP;
        end
        ST_PROP: if (div_done_q) begin
          pterm_q <= div_res; // saturates beyond twice the band
          if (first_q) begin
            pprev_q <= div_res;
          end
          st_q <= ST_INTG;
        end
        ST_INTG: if (div_done_q) begin
          // bumpless: integral starts at output minus p
          iacc_q <= first_q ? 32'(out_q << out_sh) - pterm_q
            : clamp(48'(iacc_q) + 48'(div_res), 32'sd131071);
          st_q <= ST_DERV;
        end
        ST_DERV: if (div_done_q) begin
          dterm_q <= first_q ? 32'sd0 : div_res;
          st_q <= ST_OUT;
        end
        ST_OUT: begin
          // 0..100 % then scaled to output width
          if (sum_c < 32'sd0) begin
            out_q <= 16'h0000;
          end else if (sum_c > 32'sd65535) begin
            out_q <= 16'hFFFF >> out_sh;
          end else begin
            out_q <= 16'(sum_c) >> out_sh;
          end
          pprev_q <= pterm_q;
          first_q <= 1'b0;
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // registered status outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      executing_flag <= 1'b0;
      manipulated_output <= OUT_RST;
    end else if (ce) begin
      executing_flag <= st_q != ST_IDLE || due;
      manipulated_output <= out_q;
    end
  end

endmodule

/* verification/pid_loop_engine_asserts.sv */
`timescale 1ns/1ns
// protocol and loop checks seen from the top ports
module pid_loop_engine_asserts import pid_pkg::*; #(
  parameter int UNIT10_CYC = UNIT10_CYC_DEF,
  parameter int UNIT100_CYC = UNIT100_CYC_DEF
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // loop status
  input wire logic [15:0] manipulated_output,
  input wire logic error_flag,
  input wire logic executing_flag
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both halves of a write taken at one edge
  sequence s_wr_pair;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // an update begins
  sequence s_upd_start;
    $rose(executing_flag);
  endsequence
  // the pair is held one cycle before the response is raised
  a_wr_answer: assert property (s_wr_pair |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after takes");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_bresp_ends: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("write response repeated");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed while waiting");
  a_upd_bounded: assert property (
    s_upd_start |-> executing_flag [*8] ##[1:400] !executing_flag)
    else $error("update length out of bounds");
  a_err_sticky: assert property (
    $fell(error_flag) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2))
    else $error("error flag cleared without a write");
  a_out_cause: assert property (
    !$stable(manipulated_output) |-> $past(executing_flag) ||
    $past(executing_flag, 2) || $past(s_axi_wvalid, 2) ||
    $past(s_axi_wvalid, 3)) else $error("output moved with no cause");
endmodule

bind pid_loop_engine pid_loop_engine_asserts #(
  .UNIT10_CYC(UNIT10_CYC),
  .UNIT100_CYC(UNIT100_CYC)
) pid_loop_engine_asserts_i (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .manipulated_output(manipulated_output),
  .error_flag(error_flag),
  .executing_flag(executing_flag)
);

/* verification/pid_prog_model.sv */
`timescale 1ns/1ns
// user program side, reaching the words as an axi master
module pid_prog_model (
  // clock
  input wire logic aclk,
  // write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // idle at time zero
  initial begin
    {awaddr, araddr, wdata} = '1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
  end
  // one write; the edge at the start keeps nets from double drives
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a; // released lines do not keep the last value
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  // one read
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

/* verification/pid_loop_engine_bench.sv */
`timescale 1ns/1ns
// self-checking bench for the loop engine
module pid_loop_engine_bench import pid_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1; // dropped once to check that state freezes
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [15:0] mv;
  logic err, busy;
  int n_errors = 0;
  int checks_done = 0;
  // sv 0, band 10.0%, no integral, no derivative, period 100 units
  logic [15:0] par [7] = '{16'h0, 16'h0100, 16'h9999, 16'h0, 16'h0100,
                           16'h0001, 16'h0000};
  logic [15:0] bad [2] = '{16'h0020, 16'h0009}; // unit 2, out range 9
  always #2 aclk = ~aclk;
  // short time units keep the run brief
  pid_loop_engine #(.UNIT10_CYC(4), .UNIT100_CYC(8)) pid_loop_engine_i (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .manipulated_output(mv), .error_flag(err), .executing_flag(busy));
  pid_prog_model pid_prog_model_i (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected word at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected resp at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic [1:0] r;
    pid_prog_model_i.wr(a, d, r);
    cmp_resp(r, er);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    pid_prog_model_i.rd(a, d, r);
    cmp_word(d, ed);
    cmp_resp(r, er);
  endtask
  // one whole update, waits bounded; a stuck flag shows as a mismatch
  task automatic wait_upd;
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    while (busy !== 1'b0 && n < 6000) begin
      @(posedge aclk);
      n++;
    end
    cmp_word({31'h0, busy}, 32'h0);
    repeat (2) @(posedge aclk); // output copy trails by one cycle
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // watchdog well past the expected run
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(REG_STAT, 32'h0, RESP_OK);
    rdc(REG_PAR6, {16'h0, PAR_RST}, RESP_OK);
    rdc(8'h2C, 32'h0, RESP_SLVERR);
    wrc(8'h02, 32'h1, RESP_SLVERR);
    cmp_word({16'h0, mv}, {16'h0, OUT_RST});
    $display("test reset done");
    wrc(REG_OUT, 32'h40, RESP_OK);
    rdc(REG_OUT, 32'h40, RESP_OK);
    cmp_word({16'h0, mv}, 32'h40);
    for (int i = 0; i < 7; i++) wrc(REG_PAR0 + 8'(4 * i), {16'h0, par[i]},
                                    RESP_OK);
    $display("test manual done");
    // direct action from rest, then a step above the target
    wrc(REG_INP, 32'h0, RESP_OK);
    wrc(REG_CTRL, 32'h1, RESP_OK);
    wait_upd();
    cmp_word({16'h0, mv}, 32'h40);
    wrc(REG_PAR0 + 8'h04, 32'h9999, RESP_OK); // wide band, must be ignored
    wrc(REG_OUT, 32'h11, RESP_OK);
    rdc(REG_OUT, 32'h40, RESP_OK);
    wrc(REG_INP, 32'h20, RESP_OK);
    // frozen past the due update: the output must not move
    ce <= 1'b0;
    repeat (2000) @(posedge aclk);
    cmp_word({16'h0, mv}, 32'h40);
    ce <= 1'b1;
    wait_upd();
    wait_upd();
    cmp_word({16'h0, mv}, 32'hFF);
    $display("test direct done");
    // stop holds the output; restart in reverse from full scale
    wrc(REG_CTRL, 32'h0, RESP_OK);
    repeat (900) @(posedge aclk);
    cmp_word({16'h0, mv}, 32'hFF);
    wrc(REG_PAR0 + 8'h04, 32'h0100, RESP_OK);
    wrc(REG_PAR0 + 8'h14, 32'h0000, RESP_OK);
    wrc(REG_CTRL, 32'h1, RESP_OK);
    wait_upd();
    cmp_word({16'h0, mv}, 32'hFF);
    wrc(REG_INP, 32'h60, RESP_OK);
    wait_upd();
    wait_upd();
    cmp_word({16'h0, mv}, 32'h0);
    $display("test reverse done");
    // illegal codes raise the flag and keep the loop stopped
    for (int i = 0; i < 2; i++) begin
      wrc(REG_CTRL, 32'h0, RESP_OK);
      wrc(REG_PAR6, {16'h0, bad[i]}, RESP_OK);
      wrc(REG_CTRL, 32'h1, RESP_OK);
      repeat (4) @(posedge aclk);
      cmp_word({31'h0, err}, 32'h1);
      rdc(REG_STAT, 32'h1, RESP_OK);
      wrc(REG_CTRL, 32'h0, RESP_OK);
      wrc(REG_STAT, 32'h1, RESP_OK);
      rdc(REG_STAT, 32'h0, RESP_OK);
    end
    $display("test error done");
    tally_and_finish();
  end
endmodule
